// >>> rtl/sac_cfg.svh
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ****************************************************************
// Conversion sequencing, counted in converter clock ticks
// ****************************************************************
`define SAC_CONV_CYCLES   4'd13
`define SAC_LAST_CYCLE    4'd12
`define SAC_SAMPLE_CYCLE  4'd2
`define SAC_CYC_ZERO      4'h0
`define SAC_CYC_ONE       4'h1

// ****************************************************************
// Widths and field values
// ****************************************************************
`define SAC_RES_W         10
`define SAC_SAR_MSB       10'h200
`define SAC_SAR_ZERO      10'h000
`define SAC_SAR_LSB       10'h001
`define SAC_MUX_W         5
`define SAC_MUX_OFF       5'h00
`define SAC_REF_OFF       2'h0
`define SAC_SAMPNUM_MAX   3'h6
`define SAC_BURST_ONE     7'h01
`define SAC_BURST_ZERO    7'h00
`define SAC_DLY_ZERO      5'h00
`define SAC_DLY_ONE       5'h01
`define SAC_PRESCALE_SELECT_BASE    9'h002
`define SAC_PRESCALE_SELECT_ONE     9'h001
`define SAC_PRESCALE_SELECT_ZERO    9'h000
`define SAC_LFSR_SEED     8'ha5

`endif

// >>> rtl/sac_pkg.sv
package sac_pkg;

  // Gray coded along idle -> converting -> delaying.
  typedef enum logic [1:0]
  {
    SAC_IDLE  = 2'h0,
    SAC_CONV  = 2'h1,
    SAC_DELAY = 2'h3
  } sac_state_e;

  typedef enum logic [2:0]
  {
    SAC_WIN_NONE    = 3'h0,
    SAC_WIN_BELOW   = 3'h1,
    SAC_WIN_ABOVE   = 3'h2,
    SAC_WIN_INSIDE  = 3'h3,
    SAC_WIN_OUTSIDE = 3'h4
  } sac_win_e;

endpackage : sac_pkg

// >>> rtl/sac_ctl_if.sv
`timescale 1ns/1ps

interface sac_ctl_if;
  logic       enable;
  logic       run;
  logic [2:0] prescale_select;
  logic       tick;
  logic       rand_step;
  logic [3:0] rand_val;

  modport ctl
  (
    output enable,
    output run,
    output prescale_select,
    input  tick,
    output rand_step,
    input  rand_val
  );

  modport pre
  (
    input  enable,
    input  run,
    input  prescale_select,
    output tick
  );

  modport rng
  (
    input  rand_step,
    output rand_val
  );
endinterface : sac_ctl_if

// >>> rtl/sac_prescaler.sv
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_prescaler
  import sac_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  sac_ctl_if.pre    bus
);

  logic [8:0] cnt_r;
  logic [8:0] lim;

  // Division factor is 2, 4, ... 256 peripheral clocks per tick.
  assign lim = 9'((`SAC_PRESCALE_SELECT_BASE << bus.prescale_select) - `SAC_PRESCALE_SELECT_ONE);

  // Held at zero while disabled or idle, so the start delay is fixed.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= `SAC_PRESCALE_SELECT_ZERO;
    else if (!(bus.enable && bus.run)) // see R13
      cnt_r <= `SAC_PRESCALE_SELECT_ZERO;
    else if (cnt_r >= lim)
      cnt_r <= `SAC_PRESCALE_SELECT_ZERO;
    else
      cnt_r <= cnt_r + `SAC_PRESCALE_SELECT_ONE;
  end

  // Converter clock derived from the peripheral clock.
  assign bus.tick = bus.enable && bus.run && (cnt_r >= lim); // see R11

  a_prescale_select_held: assert property ( // see R13
    @(posedge clk) disable iff (!rst_n)
    !bus.enable |=> cnt_r == `SAC_PRESCALE_SELECT_ZERO)
    else $error("prescaler ran while disabled");

endmodule : sac_prescaler

// >>> rtl/sac_lfsr.sv
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_lfsr
  import sac_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  sac_ctl_if.rng    bus
);

  logic [7:0] lfsr_r;
  logic       fb;

  assign fb = lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3];

  // Advances once per sample so the spacing changes from sample to sample.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_r <= `SAC_LFSR_SEED;
    else if (bus.rand_step) // see R10
      lfsr_r <= {lfsr_r[6:0], fb};
  end

  assign bus.rand_val = lfsr_r[3:0];

  a_lfsr_alive: assert property ( // see R10
    @(posedge clk) disable iff (!rst_n)
    lfsr_r != 8'h00)
    else $error("lfsr locked at zero");

endmodule : sac_lfsr

// >>> rtl/sac_converter_control.sv
// Functional notes
// R1: The latched input channel select drives the analog multiplexer.
// R2: Channel and reference selects reach the converter only while enabled.
// R3: A single-sample result sits in the low 10 bits of the result.
// R4: A conversion starts on the software command or a routed event.
// R5: Single mode stops after one result, free-running mode restarts.
// R6: A completed result sets the ready flag that can raise a request.
// R7: Window compare flags results below, above, inside or outside.
// R8: A burst sums 1 to 64 samples into one result.
// R9: A programmable tick delay is inserted between burst samples.
// R10: An optional random term varies that inter-sample delay.
// R11: The converter clock comes from the peripheral clock via a prescaler.
// R12: One conversion lasts thirteen converter clock ticks.
// R13: The prescaler is held at zero whenever the enable bit is clear.
// R14: The start command reads one while busy and clears at completion.
// R15: The event input starts one conversion per rising edge.
// R16: The accumulator is sixteen bits so 64 full samples cannot overflow.
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_converter_control
  import sac_pkg::*;
#(
  parameter int ACC_W = 16
)
(
  input  wire logic                  CLOCK,
  input  wire logic                  RST_N,
  input  wire logic                  ENABLE,
  input  wire logic                  FREE_RUN,
  input  wire logic                  START_CMD,
  input  wire logic                  START_EVENT_EN,
  input  wire logic                  EVENT_IN,
  input  wire logic [4:0]            INPUT_CHANNEL_SELECT,
  input  wire logic [1:0]            REF_SELECT,
  input  wire logic [2:0]            PRESCALE_SELECT,
  input  wire logic [2:0]            SAMPLE_COUNT_SELECT,
  input  wire logic [3:0]            SAMPLE_DELAY,
  input  wire logic                  DELAY_VARIATION_EN,
  input  wire logic [2:0]            WINDOW_MODE,
  input  wire logic [ACC_W-1:0]      WINDOW_LOW,
  input  wire logic [ACC_W-1:0]      WINDOW_HIGH,
  input  wire logic                  RESULT_READY_IE,
  input  wire logic                  WINDOW_IE,
  input  wire logic                  RESULT_READ,
  input  wire logic                  RESULT_READY_CLEAR,
  input  wire logic                  WINDOW_FLAG_CLEAR,
  input  wire logic                  COMPARATOR_IN,
  output logic                       ANALOG_ENABLE,
  output logic [4:0]                 ANALOG_MUX_SEL,
  output logic [1:0]                 ANALOG_REF_SEL,
  output logic                       SAMPLE_HOLD,
  output logic [9:0]                 SAR_TRIAL,
  output logic [ACC_W-1:0]           CONVERSION_RESULT,
  output logic                       START_CONVERSION_CMD,
  output logic                       RESULT_READY_FLAG,
  output logic                       WINDOW_FLAG,
  output logic                       IRQ
);

  // ****************************************************************
  // Reset release and sub-blocks
  // ****************************************************************
  logic       rst_s1_r;
  logic       rst_n;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  sac_ctl_if ctl ();

  sac_prescaler u_prescale_select
  (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .bus   (ctl.pre)
  );

  sac_lfsr u_lfsr
  (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .bus   (ctl.rng)
  );

  // ****************************************************************
  // Start requests
  // ****************************************************************
  sac_state_e           state_r;
  sac_state_e           state_nxt;
  logic                 ev_d_r;
  logic                 ev_rise;
  logic                 start_req;
  logic [3:0]           cyc_r;
  logic [4:0]           dly_r;
  logic [4:0]           dly_amt;
  logic [6:0]           cnt_r;
  logic [6:0]           target;
  logic                 conv_tick;
  logic                 samp_done;
  logic                 burst_done;
  logic                 enter_conv;
  logic [9:0]           mask_r;
  logic [9:0]           keep;
  logic [ACC_W-1:0]     acc_r;
  logic [ACC_W-1:0]     sum;
  logic                 win_hit;

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      ev_d_r <= 1'b0;
    else
      ev_d_r <= EVENT_IN;
  end

  assign ev_rise   = EVENT_IN && !ev_d_r; // see R15
  assign start_req = START_CMD || (START_EVENT_EN && ev_rise); // see R4

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign target = (SAMPLE_COUNT_SELECT > `SAC_SAMPNUM_MAX)
                ? 7'(`SAC_BURST_ONE << `SAC_SAMPNUM_MAX)
                : 7'(`SAC_BURST_ONE << SAMPLE_COUNT_SELECT); // see R8
  assign dly_amt = {1'b0, SAMPLE_DELAY}
                 + (DELAY_VARIATION_EN ? {1'b0, ctl.rand_val}
                                       : `SAC_DLY_ZERO); // see R9 R10
  assign conv_tick  = ctl.tick && (state_r == SAC_CONV);
  assign samp_done  = conv_tick && (cyc_r == `SAC_LAST_CYCLE); // see R12
  // A count lowered in mid-burst ends the burst instead of wrapping.
  assign burst_done = samp_done && (cnt_r + `SAC_BURST_ONE >= target);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SAC_IDLE:
      begin
        if (ENABLE && start_req)
          state_nxt = SAC_CONV;
      end
      SAC_CONV:
      begin
        if (!ENABLE)
          state_nxt = SAC_IDLE;
        else if (burst_done)
          state_nxt = FREE_RUN ? SAC_CONV : SAC_IDLE; // see R5
        else if (samp_done && dly_amt != `SAC_DLY_ZERO)
          state_nxt = SAC_DELAY;
      end
      SAC_DELAY:
      begin
        if (!ENABLE)
          state_nxt = SAC_IDLE;
        else if (ctl.tick && dly_r == `SAC_DLY_ONE)
          state_nxt = SAC_CONV;
      end
      default:
        state_nxt = SAC_IDLE;
    endcase
  end

  assign enter_conv = (state_r == SAC_IDLE) && (state_nxt == SAC_CONV);

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= SAC_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      cyc_r <= `SAC_CYC_ZERO;
    else if (state_r != SAC_CONV || samp_done)
      cyc_r <= `SAC_CYC_ZERO;
    else if (conv_tick)
      cyc_r <= cyc_r + `SAC_CYC_ONE; // see R12
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      dly_r <= `SAC_DLY_ZERO;
    else if (samp_done)
      dly_r <= dly_amt; // see R9
    else if (state_r == SAC_DELAY && ctl.tick)
      dly_r <= dly_r - `SAC_DLY_ONE;
  end

  assign ctl.enable    = ENABLE;
  assign ctl.run       = (state_r != SAC_IDLE);
  assign ctl.prescale_select     = PRESCALE_SELECT;
  assign ctl.rand_step = samp_done; // see R10

  // Busy reads as the command bit; it drops with the last result.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      START_CONVERSION_CMD <= 1'b0;
    else
      START_CONVERSION_CMD <= (state_nxt != SAC_IDLE); // see R14
  end

  // ****************************************************************
  // Analog selects
  // ****************************************************************
  // Latching at start keeps the channel steady until the burst ends.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ANALOG_ENABLE  <= 1'b0;
      ANALOG_MUX_SEL <= `SAC_MUX_OFF;
      ANALOG_REF_SEL <= `SAC_REF_OFF;
    end
    else if (!ENABLE)
    begin
      ANALOG_ENABLE  <= 1'b0;
      ANALOG_MUX_SEL <= `SAC_MUX_OFF; // see R2
      ANALOG_REF_SEL <= `SAC_REF_OFF;
    end
    else
    begin
      ANALOG_ENABLE  <= 1'b1;
      ANALOG_REF_SEL <= REF_SELECT; // see R2
      if (state_r == SAC_IDLE)
        ANALOG_MUX_SEL <= INPUT_CHANNEL_SELECT; // see R1
    end
  end

  // ****************************************************************
  // Successive approximation
  // ****************************************************************
  assign keep = COMPARATOR_IN ? SAR_TRIAL : (SAR_TRIAL & ~mask_r);

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SAR_TRIAL   <= `SAC_SAR_ZERO;
      mask_r      <= `SAC_SAR_ZERO;
      SAMPLE_HOLD <= 1'b0;
    end
    else
    begin
      SAMPLE_HOLD <= conv_tick && (cyc_r == `SAC_SAMPLE_CYCLE);
      if (conv_tick && cyc_r == `SAC_SAMPLE_CYCLE)
      begin
        SAR_TRIAL <= `SAC_SAR_MSB;
        mask_r    <= `SAC_SAR_MSB;
      end
      else if (conv_tick && cyc_r > `SAC_SAMPLE_CYCLE)
      begin
        SAR_TRIAL <= keep | (mask_r >> 1);
        mask_r    <= mask_r >> 1;
      end
    end
  end

  // ****************************************************************
  // Accumulation and result
  // ****************************************************************
  assign sum = acc_r + ACC_W'(keep); // see R3 R16

  always_comb
  begin
    case (WINDOW_MODE)
      SAC_WIN_BELOW:   win_hit = sum < WINDOW_LOW;
      SAC_WIN_ABOVE:   win_hit = sum > WINDOW_HIGH;
      SAC_WIN_INSIDE:  win_hit = sum >= WINDOW_LOW && sum <= WINDOW_HIGH;
      SAC_WIN_OUTSIDE: win_hit = sum < WINDOW_LOW || sum > WINDOW_HIGH;
      default:         win_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r             <= '0;
      cnt_r             <= `SAC_BURST_ZERO;
      CONVERSION_RESULT <= '0;
    end
    else if (enter_conv || burst_done || state_r == SAC_IDLE)
    begin
      acc_r <= '0;
      cnt_r <= `SAC_BURST_ZERO;
      if (burst_done)
        CONVERSION_RESULT <= sum; // see R8
    end
    else if (samp_done)
    begin
      acc_r <= sum; // see R16
      cnt_r <= cnt_r + `SAC_BURST_ONE;
    end
  end

  // Set wins over a clear in the same cycle so no result is missed.
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      RESULT_READY_FLAG <= 1'b0;
    else if (burst_done)
      RESULT_READY_FLAG <= 1'b1; // see R6
    else if (RESULT_READ || RESULT_READY_CLEAR)
      RESULT_READY_FLAG <= 1'b0;
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      WINDOW_FLAG <= 1'b0;
    else if (burst_done && win_hit)
      WINDOW_FLAG <= 1'b1; // see R7
    else if (WINDOW_FLAG_CLEAR)
      WINDOW_FLAG <= 1'b0;
  end

  assign IRQ = (RESULT_READY_FLAG && RESULT_READY_IE)
            || (WINDOW_FLAG && WINDOW_IE); // see R6 R7

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  sequence s_idle_start;
    state_r == SAC_IDLE && ENABLE && start_req;
  endsequence

  sequence s_single_end;
    burst_done && !FREE_RUN;
  endsequence

  a_start_busy: assert property ( // see R4
    s_idle_start |=> START_CONVERSION_CMD && state_r == SAC_CONV)
    else $error("start request did not begin a conversion");

  a_single_clears: assert property ( // see R14
    s_single_end |=> !START_CONVERSION_CMD && RESULT_READY_FLAG)
    else $error("single conversion did not finish cleanly");

  a_free_continues: assert property ( // see R5
    burst_done && FREE_RUN && ENABLE
    |=> START_CONVERSION_CMD && state_r == SAC_CONV)
    else $error("free running mode stopped");

  a_mux_gated: assert property ( // see R2
    !ENABLE |=> ANALOG_MUX_SEL == `SAC_MUX_OFF && !ANALOG_ENABLE)
    else $error("analog select applied while disabled");

  a_event_level: assert property ( // see R15
    state_r == SAC_IDLE && ev_d_r && EVENT_IN
    && !START_CMD |=> state_r == SAC_IDLE)
    else $error("event level started a conversion");

  a_conv_length: assert property ( // see R12
    conv_tick && cyc_r != `SAC_LAST_CYCLE
    |=> cyc_r == $past(cyc_r) + `SAC_CYC_ONE
    && cyc_r < `SAC_CONV_CYCLES)
    else $error("conversion length is not thirteen ticks");

  a_hold_pulse: assert property ( // see R12
    conv_tick && cyc_r == `SAC_SAMPLE_CYCLE
    |=> SAMPLE_HOLD && SAR_TRIAL == `SAC_SAR_MSB)
    else $error("sample point not at the third tick");

  a_single_width: assert property ( // see R3
    burst_done && target == `SAC_BURST_ONE
    |=> CONVERSION_RESULT[ACC_W-1:`SAC_RES_W] == '0)
    else $error("single result not right adjusted");

  a_window_below: assert property ( // see R7
    burst_done && ENABLE
    && WINDOW_MODE == SAC_WIN_BELOW && sum < WINDOW_LOW
    |=> WINDOW_FLAG)
    else $error("below threshold result not flagged");

  a_burst_bound: assert property ( // see R8
    cnt_r < target)
    else $error("burst sample count exceeded");

endmodule : sac_converter_control

// >>> sim/sac_converter_control_test.sv
`timescale 1ns/1ps

module sac_converter_control_test;
  import sac_pkg::*;

  typedef struct packed
  {
    logic [15:0] res;
    logic        win;
  } sac_exp_s;

  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  logic        CLOCK, RST_N, ENABLE, FREE_RUN, START_CMD;
  logic        START_EVENT_EN, EVENT_IN, DELAY_VARIATION_EN;
  logic        RESULT_READY_IE, WINDOW_IE, RESULT_READ;
  logic        RESULT_READY_CLEAR, WINDOW_FLAG_CLEAR, COMPARATOR_IN;
  logic [4:0]  INPUT_CHANNEL_SELECT;
  logic [1:0]  REF_SELECT;
  logic [2:0]  PRESCALE_SELECT, SAMPLE_COUNT_SELECT, WINDOW_MODE;
  logic [3:0]  SAMPLE_DELAY;
  logic [15:0] WINDOW_LOW, WINDOW_HIGH, CONVERSION_RESULT;
  logic        ANALOG_ENABLE, SAMPLE_HOLD, START_CONVERSION_CMD;
  logic        RESULT_READY_FLAG, WINDOW_FLAG, IRQ;
  logic [4:0]  ANALOG_MUX_SEL;
  logic [1:0]  ANALOG_REF_SEL;
  logic [9:0]  SAR_TRIAL;
  logic [9:0]  vin;
  logic        rr_prev;
  sac_exp_s    exp_q[$];
  sac_exp_s    mon_e;
  int          errors, total_checks, seed_dummy, d, lo;
  logic        win;

  sac_converter_control #(.ACC_W(16)) dut_u
  (
    .CLOCK(CLOCK), .RST_N(RST_N), .ENABLE(ENABLE), .FREE_RUN(FREE_RUN),
    .START_CMD(START_CMD), .START_EVENT_EN(START_EVENT_EN),
    .EVENT_IN(EVENT_IN), .INPUT_CHANNEL_SELECT(INPUT_CHANNEL_SELECT),
    .REF_SELECT(REF_SELECT), .PRESCALE_SELECT(PRESCALE_SELECT),
    .SAMPLE_COUNT_SELECT(SAMPLE_COUNT_SELECT), .SAMPLE_DELAY(SAMPLE_DELAY),
    .DELAY_VARIATION_EN(DELAY_VARIATION_EN), .WINDOW_MODE(WINDOW_MODE),
    .WINDOW_LOW(WINDOW_LOW), .WINDOW_HIGH(WINDOW_HIGH),
    .RESULT_READY_IE(RESULT_READY_IE), .WINDOW_IE(WINDOW_IE),
    .RESULT_READ(RESULT_READ), .RESULT_READY_CLEAR(RESULT_READY_CLEAR),
    .WINDOW_FLAG_CLEAR(WINDOW_FLAG_CLEAR), .COMPARATOR_IN(COMPARATOR_IN),
    .ANALOG_ENABLE(ANALOG_ENABLE), .ANALOG_MUX_SEL(ANALOG_MUX_SEL),
    .ANALOG_REF_SEL(ANALOG_REF_SEL), .SAMPLE_HOLD(SAMPLE_HOLD),
    .SAR_TRIAL(SAR_TRIAL), .CONVERSION_RESULT(CONVERSION_RESULT),
    .START_CONVERSION_CMD(START_CONVERSION_CMD),
    .RESULT_READY_FLAG(RESULT_READY_FLAG), .WINDOW_FLAG(WINDOW_FLAG),
    .IRQ(IRQ)
  );

  initial
  begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  // An ideal comparator, so a correct search settles exactly on vin.
  always @(negedge CLOCK)
    COMPARATOR_IN <= (vin >= SAR_TRIAL);

  // ****************************************************************
  // Compare tasks and verdict
  // ****************************************************************
  task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic print_verdict;
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Result monitor
  // ****************************************************************
  always @(negedge CLOCK)
  begin
    if (RESULT_READY_FLAG === 1'b1 && rr_prev !== 1'b1)
    begin
      if (exp_q.size() == 0)
        chk1("unexpected result", 1'b0, 1'b1);
      else
      begin
        mon_e = exp_q.pop_front();
        chk16("result", mon_e.res, CONVERSION_RESULT);
        chk1("window flag", mon_e.win, WINDOW_FLAG);
      end
    end
    rr_prev = RESULT_READY_FLAG;
  end

  // ****************************************************************
  // Conversion driver; kind 0 waits only, 1 software, 2 event
  // ****************************************************************
  task automatic run_conv(int kind, int lo_n, int hi_n,
                          logic [15:0] res, logic w);
    int         n;
    int         nh;
    int         ns;
    logic [4:0] chan;
    exp_q.push_back('{res, w});
    nh = 0;
    ns = 1 << ((SAMPLE_COUNT_SELECT > 3'h6) ? 6 : SAMPLE_COUNT_SELECT);
    if (kind == 1)
      START_CMD = 1'b1;
    if (kind == 2)
      EVENT_IN = 1'b1;
    n = 0;
    chan = INPUT_CHANNEL_SELECT;
    do
    begin
      @(negedge CLOCK);
      n++;
      START_CMD = 1'b0;
      if (SAMPLE_HOLD === 1'b1)
        nh++;
      if (n == 1 && kind != 0)
        chk1("busy", 1'b1, START_CONVERSION_CMD);
      if (n == 4)
        INPUT_CHANNEL_SELECT = chan ^ 5'h01;
      if (n == 6 && kind != 0)
        chk16("frozen mux", 16'(chan), 16'(ANALOG_MUX_SEL));
    end
    while (RESULT_READY_FLAG !== 1'b1 && n < 4000);
    chk1("duration", 1'b1, n >= lo_n && n <= hi_n);
    chk16("hold pulses", 16'(ns), 16'(nh));
    chk1("busy after", FREE_RUN, START_CONVERSION_CMD);
    chk1("irq", RESULT_READY_IE | (WINDOW_IE & w), IRQ);
    RESULT_READ = $urandom_range(0, 1);
    RESULT_READY_CLEAR = ~RESULT_READ;
    WINDOW_FLAG_CLEAR = 1'b1;
    @(negedge CLOCK);
    RESULT_READ = 1'b0;
    RESULT_READY_CLEAR = 1'b0;
    WINDOW_FLAG_CLEAR = 1'b0;
    @(negedge CLOCK);
    chk1("ready cleared", 1'b0, RESULT_READY_FLAG);
    chk1("irq cleared", 1'b0, IRQ);
  endtask : run_conv

  initial
  begin
    repeat (20000) @(posedge CLOCK);
    errors++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {RST_N, ENABLE, FREE_RUN, START_CMD, START_EVENT_EN, EVENT_IN} = '0;
    {DELAY_VARIATION_EN, RESULT_READY_IE, WINDOW_IE, RESULT_READ} = '0;
    {RESULT_READY_CLEAR, WINDOW_FLAG_CLEAR, COMPARATOR_IN} = '0;
    {INPUT_CHANNEL_SELECT, REF_SELECT, PRESCALE_SELECT} = '0;
    {SAMPLE_COUNT_SELECT, WINDOW_MODE, SAMPLE_DELAY} = '0;
    WINDOW_LOW = 16'h0100;
    WINDOW_HIGH = 16'h0300;
    vin = 10'h000;
    errors = 0;
    total_checks = 0;
    seed_dummy = $urandom(32'hc7ec6c3b);
    repeat (6) @(negedge CLOCK);
    RST_N = 1'b1;
    INPUT_CHANNEL_SELECT = 5'h07;
    REF_SELECT = 2'h2;
    repeat (3) @(negedge CLOCK);
    chk16("mux while off", 16'h0000, 16'(ANALOG_MUX_SEL));
    chk16("ref while off", 16'h0000, 16'(ANALOG_REF_SEL));
    ENABLE = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk1("analog enable", 1'b1, ANALOG_ENABLE);
    chk16("ref on", 16'h0002, 16'(ANALOG_REF_SEL));
    for (int c = 0; c < 12; c++)
    begin
      INPUT_CHANNEL_SELECT = 5'(c);
      repeat (2) @(negedge CLOCK);
      chk16("mux select", 16'(c), 16'(ANALOG_MUX_SEL));
    end
    // Every divider step doubles the tick; the sample stays exactly thirteen ticks long.
    RESULT_READY_IE = 1'b1;
    for (int p = 0; p < 3; p++)
    begin
      PRESCALE_SELECT = 3'(p);
      d = 2 << p;
      vin = 10'($urandom_range(0, 1023));
      run_conv(1, 1 + 13 * d, 1 + 13 * d, 16'(vin), 1'b0);
    end
    PRESCALE_SELECT = 3'h0;
    RESULT_READY_IE = 1'b0;
    WINDOW_IE = 1'b1;
    for (int m = 0; m < 5; m++)
    begin
      WINDOW_MODE = 3'(m);
      // The below case draws low values so its flag is sure to be set.
      vin = 10'($urandom_range(0, (m == 1) ? 255 : 1023));
      case (m)
        1: win = vin < 10'h100;
        2: win = vin > 10'h300;
        3: win = vin >= 10'h100 && vin <= 10'h300;
        4: win = vin < 10'h100 || vin > 10'h300;
        default: win = 1'b0;
      endcase
      run_conv(1, 27, 27, 16'(vin), win);
    end
    WINDOW_MODE = 3'h0;
    WINDOW_IE = 1'b0;
    SAMPLE_COUNT_SELECT = 3'h2;
    SAMPLE_DELAY = 4'h3;
    vin = 10'($urandom_range(0, 1023));
    run_conv(1, 123, 123, 16'(vin) << 2, 1'b0);
    DELAY_VARIATION_EN = 1'b1;
    run_conv(1, 123, 213, 16'(vin) << 2, 1'b0);
    // Seven is clamped to the 64-sample burst; a full scale sum must fit.
    DELAY_VARIATION_EN = 1'b0;
    SAMPLE_DELAY = 4'h0;
    SAMPLE_COUNT_SELECT = 3'h7;
    vin = 10'h3ff;
    run_conv(1, 1665, 1665, 16'hffc0, 1'b0);
    SAMPLE_COUNT_SELECT = 3'h0;
    START_EVENT_EN = 1'b1;
    vin = 10'($urandom_range(0, 1023));
    run_conv(2, 27, 27, 16'(vin), 1'b0);
    repeat (40) @(negedge CLOCK);
    chk1("level held, no restart", 1'b0, START_CONVERSION_CMD);
    EVENT_IN = 1'b0;
    START_EVENT_EN = 1'b0;
    FREE_RUN = 1'b1;
    run_conv(1, 27, 27, 16'(vin), 1'b0);
    run_conv(0, 1, 26, 16'(vin), 1'b0);
    run_conv(0, 1, 26, 16'(vin), 1'b0);
    ENABLE = 1'b0;
    repeat (2) @(negedge CLOCK);
    chk1("abort busy", 1'b0, START_CONVERSION_CMD);
    chk16("mux off again", 16'h0000, 16'(ANALOG_MUX_SEL));
    FREE_RUN = 1'b0;
    repeat (60) @(negedge CLOCK);
    chk16("pending results", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule : sac_converter_control_test
